// ---- dca_pkg.sv ----
package dca_pkg;
  // Register offsets
  localparam logic [7:0] OFS_MEM_START [4] = '{8'h3c, 8'h48, 8'ha8, 8'hb4};
  localparam logic [7:0] OFS_PCI_START [4] = '{8'h40, 8'h4c, 8'hac, 8'hb8};
  localparam logic [7:0] OFS_NEXT_DESC [4] = '{8'hbc, 8'hc0, 8'hc4, 8'hc8};
  localparam logic [7:0] OFS_LEN_WORDS [4] = '{8'hd0, 8'hd4, 8'hd8, 8'hdc};
  localparam logic [7:0] OFS_ERR_CAPTURE = 8'h50;
  localparam logic [7:0] OFS_WORDS_LEFT = 8'h64;
  localparam logic [7:0] OFS_LIVE_MEM = 8'h68;
  localparam logic [7:0] OFS_LIVE_PCI = 8'h6c;
  localparam logic [7:0] OFS_CHAIN_PRIO = 8'h80;
  localparam logic [7:0] OFS_GO = 8'h84;
  localparam logic [7:0] OFS_IRQ_CTL = 8'h88;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_ERR_CAPTURE = 32'h0000_0050;
  // Field positions
  localparam int CHAIN_LSB = 8;
  localparam int ARB_LSB = 12;
  localparam int DIR_LSB = 4;
  localparam int DMA_FAULT_FLAG_BIT = 5;
  localparam int PCI_FAULT_FLAG_BIT = 6;
  localparam int DMA_FAULT_EN_BIT = 13;
  localparam int PCI_FAULT_EN_BIT = 14;
  // Descriptor layout, in words
  localparam logic [1:0] DESC_MEM = 2'h0;
  localparam logic [1:0] DESC_PCI = 2'h1;
  localparam logic [1:0] DESC_LEN = 2'h2;
  localparam logic [1:0] DESC_NEXT = 2'h3;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  // Error kinds
  localparam logic [1:0] ERR_ILLEGAL = 2'b00;
  localparam logic [1:0] ERR_TARGET_ABORT = 2'b01;
  localparam logic [1:0] ERR_MASTER_ABORT = 2'b10;
  localparam logic [1:0] ERR_RETRY_LIMIT = 2'b11;
  // Arbitration codes
  localparam logic [1:0] ARB_ROTATE = 2'b00;
  localparam logic [1:0] ARB_FAVOUR_A = 2'b01;
  localparam logic [1:0] ARB_FAVOUR_B = 2'b10;
  localparam logic [2:0] SEQ_LEN_ROTATE = 3'd4;
  localparam logic [2:0] SEQ_LEN_FAVOUR = 3'd6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_WRITE = 3'b010,
    ST_FETCH = 3'b011,
    ST_DONE = 3'b100
  } dca_state_e;
endpackage

// ---- dca_arbiter.sv ----
`timescale 1ns/10ps
module dca_arbiter import dca_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests and scheme
  input wire logic [3:0] req,
  input wire logic [1:0] mode,
  input wire logic advance,
  // Grant
  output logic grant_valid,
  output logic [1:0] grant
);
  logic [2:0] ptr;
  logic [2:0] hit_slot;

  function automatic logic [2:0] seq_len(input logic [1:0] m);
    return (m == ARB_FAVOUR_A || m == ARB_FAVOUR_B) ? SEQ_LEN_FAVOUR : SEQ_LEN_ROTATE;
  endfunction

  function automatic logic [1:0] seq_chan(input logic [1:0] m, input logic [2:0] s);
    logic [1:0] c;
    c = s[1:0];
    if (m == ARB_FAVOUR_A) begin
      c = (s < 3'd4) ? {1'b0, s[0]} : {1'b1, s[0]};
    end else if (m == ARB_FAVOUR_B) begin
      c = (s < 3'd4) ? {1'b1, s[0]} : {1'b0, s[0]};
    end
    return c;
  endfunction

  function automatic logic [2:0] wrap(input logic [3:0] v, input logic [2:0] len);
    return (v >= {1'b0, len}) ? 3'(v - {1'b0, len}) : v[2:0];
  endfunction

  // Scan forward from the pointer so an idle channel never blocks the sequence
  always_comb begin
    logic [2:0] s;
    s = 3'd0;
    grant_valid = 1'b0;
    grant = 2'd0;
    hit_slot = 3'd0;
    for (int k = 5; k >= 0; k--) begin
      s = wrap(4'(wrap({1'b0, ptr}, seq_len(mode))) + 4'(k), seq_len(mode));
      if (k < int'(seq_len(mode)) && req[seq_chan(mode, s)]) begin
        grant_valid = 1'b1;
        grant = seq_chan(mode, s);
        hit_slot = s;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr <= 3'd0;
    end else if (advance && grant_valid) begin
      ptr <= wrap({1'b0, hit_slot} + 4'd1, seq_len(mode));
    end
  end
endmodule // dca_arbiter

// ---- dca_aligner.sv ----
`timescale 1ns/10ps
module dca_aligner import dca_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic load,
  input wire logic [1:0] shift,
  // Data
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  logic [31:0] prev;
  logic [31:0] pair;
  wire [63:0] funnel = {din, prev};

  // Bytes straddling two source words come from the previous one
  assign pair = 32'(funnel >> {shift, 3'b000});

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      prev <= RST_ZERO;
      dout <= RST_ZERO;
    end else if (load) begin
      prev <= din;
      // Aligned data passes straight through, adding no word of lag
      dout <= (shift == 2'h0) ? din : pair;
    end
  end
endmodule // dca_aligner

// ---- dca_dma_engine.sv ----
// Our own choice: strobed register access.
`timescale 1ns/10ps
module dca_dma_engine import dca_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Local memory port
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  // PCI master port
  output logic pci_req,
  output logic pci_we,
  output logic [31:0] pci_addr,
  output logic [31:0] pci_wdata,
  input wire logic pci_ack,
  input wire logic pci_err,
  input wire logic [1:0] pci_err_kind,
  input wire logic [31:0] pci_rdata,
  // PCI target window miss
  input wire logic tgt_miss,
  input wire logic [31:0] tgt_addr,
  // Interrupt to CPU
  output logic irq_n
);
  logic [31:0] mem_start [4];
  logic [31:0] pci_start [4];
  logic [31:0] next_desc [4];
  logic [31:0] len_words [4];
  logic [31:0] wk_mem [4];
  logic [31:0] wk_pci [4];
  logic [31:0] wk_cnt [4];
  logic [31:0] wk_next [4];
  logic [3:0] chain_en;
  logic [1:0] arb_mode;
  logic [3:0] pending;
  logic [3:0] dir;
  logic dma_fault_enable;
  logic pci_fault_enable;
  logic dma_fault_flag;
  logic pci_fault_flag;
  logic [1:0] error_kind;
  logic [29:0] error_location;
  logic err_locked;
  dca_state_e state;
  logic [1:0] chan;
  logic [1:0] fk;
  logic grant_valid;
  logic [1:0] grant;
  logic [31:0] xfer_word;

  // Decode
  wire wr_chain = reg_wr && reg_addr == OFS_CHAIN_PRIO;
  wire wr_go = reg_wr && reg_addr == OFS_GO;
  wire wr_irq = reg_wr && reg_addr == OFS_IRQ_CTL;
  wire rd_err = reg_rd && reg_addr == OFS_ERR_CAPTURE;

  // Data path selection; dir set means PCI to memory
  wire from_pci = dir[chan];
  // An empty structure must not raise a request that it then drops unanswered
  wire in_read = state == ST_READ && wk_cnt[chan] != RST_ZERO;
  wire in_write = state == ST_WRITE;
  wire in_fetch = state == ST_FETCH;
  wire src_ack = from_pci ? pci_ack : mem_ack;
  wire dst_ack = from_pci ? mem_ack : pci_ack;
  wire [31:0] src_data = from_pci ? pci_rdata : mem_rdata;
  wire mem_fault = mem_req && mem_err;
  wire pci_fault = pci_req && pci_err;
  wire dma_fault = mem_fault || pci_fault;
  wire [1:0] src_ofs = from_pci ? wk_pci[chan][1:0] : wk_mem[chan][1:0];
  wire [1:0] dst_ofs = from_pci ? wk_mem[chan][1:0] : wk_pci[chan][1:0];
  wire word_moved = in_write && dst_ack && !dma_fault;
  wire last_word = wk_cnt[chan] == RST_ZERO || (word_moved && wk_cnt[chan] == 32'h0000_0001);
  wire chain_on = chain_en[chan] && wk_next[chan] != RST_ZERO;
  wire fetch_word = in_fetch && mem_ack && !mem_err;

  assign mem_req = (in_read && !from_pci) || (in_write && from_pci) || in_fetch;
  assign mem_we = in_write;
  assign mem_addr = in_fetch ? wk_next[chan] + {28'h000_0000, fk, 2'b00} : wk_mem[chan];
  assign mem_wdata = xfer_word;
  assign pci_req = (in_read && from_pci) || (in_write && !from_pci);
  assign pci_we = in_write;
  assign pci_addr = wk_pci[chan];
  assign pci_wdata = xfer_word;

  // One interrupt line, OR of the enabled causes
  assign irq_n = !((dma_fault_flag && dma_fault_enable) || (pci_fault_flag && pci_fault_enable));

  dca_arbiter u_arbiter (
    .clk(clk),
    .rst_n(rst_n),
    .req(pending),
    .mode(arb_mode),
    .advance(state == ST_IDLE),
    .grant_valid(grant_valid),
    .grant(grant)
  );

  dca_aligner u_aligner (
    .clk(clk),
    .rst_n(rst_n),
    .clear(state == ST_IDLE),
    .load(in_read && src_ack && !dma_fault),
    .shift(2'(src_ofs - dst_ofs)),
    .din(src_data),
    .dout(xfer_word)
  );

  // Software-owned configuration; nothing here is touched by the engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        mem_start[i] <= RST_ZERO;
        pci_start[i] <= RST_ZERO;
        next_desc[i] <= RST_ZERO;
        len_words[i] <= RST_ZERO;
      end
    end else if (reg_wr) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_addr == OFS_MEM_START[i]) mem_start[i] <= reg_wdata;
        if (reg_addr == OFS_PCI_START[i]) pci_start[i] <= reg_wdata;
        if (reg_addr == OFS_NEXT_DESC[i]) next_desc[i] <= reg_wdata;
        if (reg_addr == OFS_LEN_WORDS[i]) len_words[i] <= reg_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chain_en <= 4'h0;
      arb_mode <= ARB_ROTATE;
      dma_fault_enable <= 1'b0;
      pci_fault_enable <= 1'b0;
    end else begin
      if (wr_chain) begin
        chain_en <= reg_wdata[CHAIN_LSB +: 4];
        arb_mode <= reg_wdata[ARB_LSB +: 2];
      end
      if (wr_irq) begin
        dma_fault_enable <= reg_wdata[DMA_FAULT_EN_BIT];
        pci_fault_enable <= reg_wdata[PCI_FAULT_EN_BIT];
      end
    end
  end

  // Engine: one structure per grant, then back to IDLE to re-arbitrate
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      chan <= 2'd0;
      fk <= 2'd0;
      pending <= 4'h0;
      dir <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        wk_mem[i] <= RST_ZERO;
        wk_pci[i] <= RST_ZERO;
        wk_cnt[i] <= RST_ZERO;
        wk_next[i] <= RST_ZERO;
      end
    end else begin
      unique case (state)
        ST_IDLE: begin
          fk <= 2'd0;
          if (grant_valid) begin
            chan <= grant;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (dma_fault) begin
            // A faulted channel must not go on to fetch its chain
            wk_next[chan] <= RST_ZERO;
            state <= ST_DONE;
          end else if (wk_cnt[chan] == RST_ZERO) begin
            state <= ST_DONE;
          end else if (src_ack) begin
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (dma_fault) begin
            wk_next[chan] <= RST_ZERO;
            state <= ST_DONE;
          end else if (dst_ack) begin
            wk_cnt[chan] <= wk_cnt[chan] - 32'h0000_0001;
            wk_mem[chan] <= wk_mem[chan] + WORD_BYTES;
            wk_pci[chan] <= wk_pci[chan] + WORD_BYTES;
            state <= last_word ? ST_DONE : ST_READ;
          end
        end
        ST_DONE: begin
          if (chain_on) begin
            state <= ST_FETCH;
          end else begin
            pending[chan] <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (mem_fault) begin
            pending[chan] <= 1'b0;
            state <= ST_IDLE;
          end else if (fetch_word) begin
            unique case (fk)
              DESC_MEM: wk_mem[chan] <= mem_rdata;
              DESC_PCI: wk_pci[chan] <= mem_rdata;
              DESC_LEN: wk_cnt[chan] <= mem_rdata;
              DESC_NEXT: wk_next[chan] <= mem_rdata;
            endcase
            fk <= 2'(fk + 2'd1);
            // Fetched structure waits for its own grant
            if (fk == DESC_NEXT) state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // Start wins only for an idle channel; running copies never touch start regs
      if (wr_go) begin
        for (int i = 0; i < 4; i++) begin
          if (reg_wdata[i] && !pending[i] && !(state != ST_IDLE && chan == 2'(i))) begin
            pending[i] <= 1'b1;
            dir[i] <= reg_wdata[DIR_LSB + i];
            wk_mem[i] <= mem_start[i];
            wk_pci[i] <= pci_start[i];
            wk_cnt[i] <= len_words[i];
            wk_next[i] <= next_desc[i];
          end
        end
      end
    end
  end

  // Error capture; a new event in the read cycle is kept, not lost
  wire can_capture = !err_locked || rd_err;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      error_kind <= RST_ERR_CAPTURE[1:0];
      error_location <= RST_ERR_CAPTURE[31:2];
      err_locked <= 1'b0;
      dma_fault_flag <= 1'b0;
      pci_fault_flag <= 1'b0;
    end else begin
      if (rd_err) begin
        err_locked <= 1'b0;
        dma_fault_flag <= 1'b0;
        pci_fault_flag <= 1'b0;
      end
      if (dma_fault) dma_fault_flag <= 1'b1;
      if (tgt_miss) pci_fault_flag <= 1'b1;
      if (can_capture) begin
        if (pci_fault) begin
          error_kind <= pci_err_kind;
          err_locked <= 1'b1;
        end else if (mem_fault) begin
          error_kind <= ERR_ILLEGAL;
          error_location <= mem_addr[31:2];
          err_locked <= 1'b1;
        end else if (tgt_miss) begin
          error_kind <= ERR_ILLEGAL;
          error_location <= tgt_addr[31:2];
          err_locked <= 1'b1;
        end
      end
    end
  end

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = RST_ZERO;
    for (int i = 0; i < 4; i++) begin
      if (reg_addr == OFS_MEM_START[i]) rd_mux = mem_start[i];
      if (reg_addr == OFS_PCI_START[i]) rd_mux = pci_start[i];
      if (reg_addr == OFS_NEXT_DESC[i]) rd_mux = next_desc[i];
      if (reg_addr == OFS_LEN_WORDS[i]) rd_mux = len_words[i];
    end
    unique case (reg_addr)
      OFS_ERR_CAPTURE: rd_mux = {error_location, error_kind};
      OFS_WORDS_LEFT: rd_mux = wk_cnt[chan];
      OFS_LIVE_MEM: rd_mux = wk_mem[chan];
      OFS_LIVE_PCI: rd_mux = wk_pci[chan];
      OFS_CHAIN_PRIO: rd_mux = {18'h0_0000, arb_mode, chain_en, 8'h00};
      OFS_GO: rd_mux = {24'h00_0000, dir, pending};
      OFS_IRQ_CTL: rd_mux = {17'h0_0000, pci_fault_enable, dma_fault_enable, 6'h00,
                             pci_fault_flag, dma_fault_flag, 5'h00};
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : RST_ZERO;
    end
  end
endmodule // dca_dma_engine

// ---- dca_dma_engine_sva.sv ----
`timescale 1ns/10ps
module dca_dma_engine_sva import dca_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Data side
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic pci_req,
  input wire logic pci_we,
  input wire logic [31:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  input wire logic pci_ack,
  input wire logic pci_err,
  // Events and interrupt
  input wire logic tgt_miss,
  input wire logic irq_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Only a fault, or enabling an already set flag, may pull the line low
  wire fault_seen = (pci_req && pci_err) || (mem_req && mem_err) || tgt_miss || (reg_wr && reg_addr == OFS_IRQ_CTL);
  wire flag_release = (reg_rd && reg_addr == OFS_ERR_CAPTURE) || (reg_wr && reg_addr == OFS_IRQ_CTL);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) < 8'h3c |-> reg_rdata == 32'h0000_0000)
    else $error("unmapped read did not return zero");
  a_mem_hold: assert property (mem_req && !mem_ack && !mem_err |=>
    mem_req && $stable({mem_we, mem_addr}) && (!mem_we || $stable(mem_wdata)))
    else $error("memory request changed before its answer");
  a_pci_hold: assert property (pci_req && !pci_ack && !pci_err |=>
    pci_req && $stable({pci_we, pci_addr}) && (!pci_we || $stable(pci_wdata)))
    else $error("bus request changed before its answer");
  a_one_side: assert property (!(mem_req && pci_req))
    else $error("memory and bus requested together");
  a_irq_fall_cause: assert property ($fell(irq_n) |-> $past(fault_seen))
    else $error("interrupt raised without a fault");
  a_irq_rise_cause: assert property ($rose(irq_n) |-> $past(flag_release))
    else $error("interrupt dropped without a status read");
  a_fault_stops: assert property (pci_req && pci_err |=> !pci_req && !mem_req)
    else $error("transfer went on after a bus fault");
  a_bus_to_mem: assert property (pci_req && pci_ack && !pci_we |-> ##[1:3] mem_req && mem_we)
    else $error("bus word not written to memory");
  c_bus_fault: cover property (pci_req && pci_err);
  c_window_miss: cover property (tgt_miss);
  c_mem_write: cover property (mem_req && mem_we && mem_ack);
endmodule // dca_dma_engine_sva

bind dca_dma_engine dca_dma_engine_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .pci_req(pci_req), .pci_we(pci_we),
  .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ack(pci_ack), .pci_err(pci_err), .tgt_miss(tgt_miss),
  .irq_n(irq_n));

// ---- dca_far_port.sv ----
`timescale 1ns/10ps
module dca_far_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Behaviour chosen by the bench
  input wire logic slow,
  input wire logic fail,
  input wire logic [1:0] fail_kind,
  // Access from the engine
  input wire logic req,
  input wire logic we,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  output logic ack,
  output logic err,
  output logic [1:0] err_kind,
  output logic [31:0] rdata
);
  logic [31:0] ram [1024];
  logic [1:0] wait_cnt;
  wire answer = req && !ack && !err && (wait_cnt == (slow ? 2'h3 : 2'h0));
  assign err_kind = fail_kind;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
      err <= 1'b0;
      wait_cnt <= 2'h0;
      rdata <= 32'h0000_0000;
    end else begin
      ack <= answer && !fail;
      err <= answer && fail;
      wait_cnt <= (!req || ack || err || answer) ? 2'h0 : wait_cnt + 2'h1;
      // Toggle outside the answer so stale data never looks valid
      rdata <= (answer && !fail) ? ram[addr[11:2]] : ~rdata;
    end
  end
  always @(posedge clk) begin
    if (ack && req && we) begin
      ram[addr[11:2]] <= wdata;
    end
  end
endmodule // dca_far_port

// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  import dca_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tgt_miss = 1'b0;
  logic [31:0] tgt_addr = 32'h0000_0000;
  logic slow = 1'b0;
  logic pci_fail = 1'b0;
  logic mem_fail = 1'b0;
  logic [1:0] pci_kind = 2'h0;
  logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, pci_addr, pci_wdata, pci_rdata;
  logic mem_req, mem_we, mem_ack, mem_err, pci_req, pci_we, pci_ack, pci_err, irq_n;
  logic [1:0] pci_err_kind;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] rdv;
  logic [31:0] order = 32'h0000_0000;
  logic [31:0] exp_order [6] = '{32'h0012_3412, 32'h0012_1234, 32'h0034_1212, 32'h0012_3412, 32'h1234_1234,
    32'h0000_1234};
  logic [1:0] modes [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
  logic [3:0] chains [6] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'hf, 4'h0};

  always #50 clk = ~clk;

  dca_dma_engine u_dca_dma_engine (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err), .mem_rdata(mem_rdata),
    .pci_req(pci_req), .pci_we(pci_we), .pci_addr(pci_addr), .pci_wdata(pci_wdata), .pci_ack(pci_ack),
    .pci_err(pci_err), .pci_err_kind(pci_err_kind), .pci_rdata(pci_rdata), .tgt_miss(tgt_miss),
    .tgt_addr(tgt_addr), .irq_n(irq_n));
  dca_far_port u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .fail(mem_fail), .fail_kind(2'h0), .req(mem_req),
    .we(mem_we), .addr(mem_addr), .wdata(mem_wdata), .ack(mem_ack), .err(mem_err), .err_kind(), .rdata(mem_rdata));
  dca_far_port u_pci (.clk(clk), .rst_n(rst_n), .slow(slow), .fail(pci_fail), .fail_kind(pci_kind), .req(pci_req),
    .we(pci_we), .addr(pci_addr), .wdata(pci_wdata), .ack(pci_ack), .err(pci_err), .err_kind(pci_err_kind),
    .rdata(pci_rdata));

  // Channel of each run of bus writes, so interleaving shows up
  always @(posedge clk) begin
    if (pci_req && pci_ack && pci_we && pci_addr[11:8] != order[3:0]) begin
      order <= {order[27:0], pci_addr[11:8]};
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rdv = reg_rdata;
    if (a != OFS_GO) begin
      chk($sformatf("reg %h", a), exp, rdv);
    end
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      rdchk(OFS_GO, 32'h0000_0000);
      if (rdv[3:0] === 4'h0) begin
        return;
      end
    end
    chk("idle", 32'h0000_0000, rdv);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  initial begin
    for (int k = 0; k < 1024; k++) begin
      u_mem.ram[k] = 32'hA000_0000 | 32'(k * 4);
      u_pci.ram[k] = 32'h5000_0000 | 32'(k * 4);
    end
    // Second-level descriptors, word aligned, last in chain
    for (int i = 0; i < 4; i++) begin
      u_mem.ram[192 + 4 * i] = 32'h0000_0280 + 32'(i * 4);
      u_mem.ram[193 + 4 * i] = 32'h0000_0180 + 32'(i * 256);
      u_mem.ram[194 + 4 * i] = 32'h0000_0001;
      u_mem.ram[195 + 4 * i] = 32'h0000_0000;
    end
    do_reset();
    rdchk(OFS_ERR_CAPTURE, RST_ERR_CAPTURE);
    rdchk(OFS_WORDS_LEFT, RST_ZERO);
    rdchk(OFS_LIVE_MEM, RST_ZERO);
    rdchk(OFS_LIVE_PCI, RST_ZERO);
    rdchk(OFS_CHAIN_PRIO, RST_ZERO);
    rdchk(8'h00, RST_ZERO);
    for (int i = 0; i < 4; i++) begin
      rdchk(OFS_MEM_START[i], RST_ZERO);
      rdchk(OFS_PCI_START[i], RST_ZERO);
      rdchk(OFS_NEXT_DESC[i], RST_ZERO);
      wr(OFS_PCI_START[i], 32'h5A5A_0000 + 32'(i));
      rdchk(OFS_PCI_START[i], 32'h5A5A_0000 + 32'(i));
    end
    wr(OFS_WORDS_LEFT, 32'hFFFF_FFFF);
    rdchk(OFS_WORDS_LEFT, RST_ZERO);
    // Bus to memory with a slow far side
    slow <= 1'b1;
    wr(OFS_MEM_START[0], 32'h0000_0040);
    wr(OFS_PCI_START[0], 32'h0000_0080);
    wr(OFS_LEN_WORDS[0], 32'h0000_0003);
    wr(OFS_GO, 32'h0000_0011);
    wait_idle();
    for (int k = 0; k < 3; k++) begin
      chk("mem word", 32'h5000_0080 + 32'(k * 4), u_mem.ram[16 + k]);
    end
    rdchk(OFS_WORDS_LEFT, RST_ZERO);
    rdchk(OFS_MEM_START[0], 32'h0000_0040);
    rdchk(OFS_PCI_START[0], 32'h0000_0080);
    rdchk(OFS_LIVE_MEM, 32'h0000_004C);
    rdchk(OFS_LIVE_PCI, 32'h0000_008C);
    slow <= 1'b0;
    // Grant order per scheme and chaining
    for (int r = 0; r < 6; r++) begin
      do_reset();
      for (int i = 0; i < 4; i++) begin
        wr(OFS_MEM_START[i], 32'h0000_0200 + 32'(i * 8));
        wr(OFS_PCI_START[i], 32'h0000_0100 * 32'(i + 1));
        wr(OFS_LEN_WORDS[i], 32'h0000_0002);
        wr(OFS_NEXT_DESC[i], 32'h0000_0300 + 32'(i * 16));
      end
      wr(OFS_CHAIN_PRIO, {18'h0, modes[r], chains[r], 8'h00});
      rdchk(OFS_CHAIN_PRIO, {18'h0, modes[r], chains[r], 8'h00});
      order <= 32'h0000_0000;
      wr(OFS_GO, 32'h0000_000F);
      wait_idle();
      chk("grant order", exp_order[r], order);
    end
    chk("bus word", 32'hA000_0200, u_pci.ram[64]);
    chk("chained word", 32'hA000_0280, u_pci.ram[96]);
    // Bus faults of kinds 1 to 3
    wr(OFS_IRQ_CTL, 32'h0000_6000);
    pci_fail <= 1'b1;
    for (int k = 1; k < 4; k++) begin
      pci_kind <= 2'(k);
      wr(OFS_GO, 32'h0000_0001);
      wait_idle();
      chk("irq_n", 32'h0000_0000, {31'h0, irq_n});
      rdchk(OFS_ERR_CAPTURE, RST_ERR_CAPTURE | 32'(k));
      chk("irq_n", 32'h0000_0001, {31'h0, irq_n});
    end
    wr(OFS_IRQ_CTL, 32'h0000_4000);
    wr(OFS_GO, 32'h0000_0001);
    wait_idle();
    chk("irq_n", 32'h0000_0001, {31'h0, irq_n});
    rdchk(OFS_IRQ_CTL, 32'h0000_4020);
    rdchk(OFS_ERR_CAPTURE, RST_ERR_CAPTURE | 32'h0000_0003);
    pci_fail <= 1'b0;
    // Two window misses back to back; the first is kept
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      tgt_miss <= 1'b1;
      tgt_addr <= k ? 32'h0000_0ABC : 32'h1234_567B;
    end
    @(posedge clk);
    tgt_miss <= 1'b0;
    @(posedge clk);
    #1;
    chk("irq_n", 32'h0000_0000, {31'h0, irq_n});
    rdchk(OFS_ERR_CAPTURE, 32'h1234_5678);
    chk("irq_n", 32'h0000_0001, {31'h0, irq_n});
    // Memory fault captures its location; an empty structure ends at once
    mem_fail <= 1'b1;
    wr(OFS_GO, 32'h0000_0001);
    wait_idle();
    rdchk(OFS_ERR_CAPTURE, 32'h0000_0200);
    mem_fail <= 1'b0;
    wr(OFS_LEN_WORDS[1], RST_ZERO);
    wr(OFS_GO, 32'h0000_0002);
    wait_idle();
    rdchk(OFS_WORDS_LEFT, RST_ZERO);
    rdchk(OFS_LIVE_PCI, 32'h0000_0200);
    report_and_stop();
  end
endmodule // tb
